// ===== dv/cbo_ctrl_monitor.sv
`timescale 1ns/1ps
// ****
// Port checks on the control registers
// ****
module cbo_ctrl_monitor (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input cbo_pkg::cbo_reg_req_t i_req,
    input wire logic i_wakeup,
    input wire logic i_command_done,
    input wire logic o_power_down,
    input wire logic o_radio_power_down,
    input wire logic [4:0] o_command,
    input wire logic o_ownership_unlock,
    input wire logic o_host_owns_bus,
    input wire logic o_secure_module_owns_bus,
    input cbo_pkg::cbo_link_t o_secure_module_link_select
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Taken writes per register
    wire cmd_wr = i_ce && i_req.wr && i_req.addr == 7'h00;
    wire own_wr = i_ce && i_req.wr && i_req.addr == 7'h01;
    wire both = own_wr && i_req.wdata[6] && i_req.wdata[5];
    standby_write_a: assert property (
        cmd_wr ##1 (i_ce && !i_wakeup) |=> o_power_down == $past(i_req.wdata[7], 2)) else $error("standby");
    radio_write_a: assert property (
        cmd_wr ##1 i_ce |=> o_radio_power_down == $past(i_req.wdata[6], 2)) else $error("radio");
    code_write_a: assert property (
        cmd_wr ##1 (i_ce && !i_command_done) |=> o_command == $past(i_req.wdata[4:0], 2)) else $error("code");
    // Any write that cannot arm leaves the unlock clear; pins lag two edges
    unlock_spent_a: assert property (
        i_ce && i_req.wr && !(own_wr && i_req.wdata[7]) ##1 i_ce |=> !o_ownership_unlock) else $error("unlock");
    // An arming write while already armed spends it instead
    rearm_spent_a: assert property (
        own_wr && i_req.wdata[7] ##1 (i_ce && o_ownership_unlock) |=> !o_ownership_unlock) else $error("rearm");
    owner_exclusive_a: assert property (!(o_host_owns_bus && o_secure_module_owns_bus)) else $error("owners");
    host_gate_a: assert property ($rose(o_host_owns_bus) |-> $past(o_ownership_unlock)) else $error("host");
    secure_gate_a: assert property (
        $rose(o_secure_module_owns_bus) |-> $past(o_ownership_unlock)) else $error("secure");
    link_write_a: assert property (
        own_wr ##1 i_ce |=> o_secure_module_link_select == $past(i_req.wdata[3:2], 2)) else $error("link");
    both_owner_a: assert property (both ##1 (i_ce && !i_req.wr) |=>
        $stable(o_host_owns_bus) && $stable(o_secure_module_owns_bus)) else $error("both");
    cover property ($rose(o_host_owns_bus));
    cover property ($rose(o_secure_module_owns_bus));
    cover property (both);
    cover property (own_wr && i_req.wdata[7] ##1 o_ownership_unlock);
endmodule
bind cbo_command_and_bus_ownership_ctrl cbo_ctrl_monitor u_mon (.*);

// ===== dv/cbo_host_model.sv
`timescale 1ns/1ps
// ****
// Host controller issuing register accesses
// ****
module cbo_host_model (
    input wire logic i_clk,
    output cbo_pkg::cbo_reg_req_t o_req
);
    initial o_req = '0;
    // One access held across one rising edge; idle bus shows inverted junk
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 7'h00) ? 8'hDF : 8'hEC;
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d & m};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ===== dv/test_command_and_bus_ownership_ctrl.sv
`timescale 1ns/1ps
module test_command_and_bus_ownership_ctrl;
    logic i_clk = 0, i_rst_b = 0, i_ce = 1, done = 0, wake = 0;
    cbo_pkg::cbo_reg_req_t req;
    cbo_pkg::cbo_link_t link;
    logic [7:0] rdata;
    logic [4:0] cmd;
    logic rv, pd, rpd, ul, ho, so;
    int n_fail = 0, num_checks = 0;
    // Command write data beside expected image
    logic [15:0] rows [4] = '{16'hFFDF, 16'h9F9F, 16'h4040, 16'h0000};
    initial forever #2.5 i_clk = ~i_clk;
    cbo_host_model host (.i_clk(i_clk), .o_req(req));
    cbo_command_and_bus_ownership_ctrl dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_req(req),
        .i_command_done(done), .i_wakeup(wake), .o_rdata(rdata), .o_rvalid(rv), .o_power_down(pd),
        .o_radio_power_down(rpd), .o_command(cmd), .o_ownership_unlock(ul), .o_host_owns_bus(ho),
        .o_secure_module_owns_bus(so), .o_secure_module_link_select(link));
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Write, then let outputs settle one more edge
    task wr(input logic [6:0] a, input logic [7:0] d);
        host.acc(1'b1, a, d);
        @(negedge i_clk);
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00);
        chk({7'h00, rv}, 8'h01);
        chk(rdata, e);
    endtask
    initial begin
        repeat (6) @(negedge i_clk);
        i_rst_b = 1;
        chk({pd, rpd, 1'b0, cmd}, 8'h00);
        foreach (rows[i]) begin
            wr(7'h00, rows[i][15:8]);
            chk({pd, rpd, 1'b0, cmd}, rows[i][7:0]);
            rd(7'h00, rows[i][7:0]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(7'h01, {4'h0, 2'(k), 2'h0});
            chk({6'h00, link}, 8'(k));
            rd(7'h01, {4'h0, 2'(k), 2'h0});
        end
        $display("rows done");
        wr(7'h01, 8'h40);
        chk({5'h00, ul, ho, so}, 8'h00);
        wr(7'h01, 8'h80);
        chk({5'h00, ul, ho, so}, 8'h04);
        wr(7'h01, 8'h60);
        chk({5'h00, ul, ho, so}, 8'h00);
        wr(7'h01, 8'h80);
        wr(7'h01, 8'h80);
        chk({5'h00, ul, ho, so}, 8'h00);
        wr(7'h01, 8'h80);
        wr(7'h01, 8'h40);
        chk({5'h00, ul, ho, so}, 8'h02);
        wr(7'h01, 8'h20);
        chk({5'h00, ul, ho, so}, 8'h02);
        wr(7'h01, 8'h80);
        wr(7'h00, 8'h00);
        chk({5'h00, ul, ho, so}, 8'h02);
        wr(7'h01, 8'h80);
        wr(7'h01, 8'h20);
        chk({5'h00, ul, ho, so}, 8'h01);
        rd(7'h01, 8'h20);
        rd(7'h7F, 8'h00);
        $display("ownership done");
        wr(7'h00, 8'h85);
        wake = 1;
        done = 1;
        @(negedge i_clk);
        wake = 0;
        done = 0;
        @(negedge i_clk);
        chk({pd, 2'h0, cmd}, 8'h00);
        // Write and hardware clear in one cycle: the write wins
        fork
            host.acc(1'b1, 7'h00, 8'h85);
            begin
                @(negedge i_clk);
                wake = 1;
                done = 1;
                @(negedge i_clk);
                wake = 0;
                done = 0;
            end
        join
        @(negedge i_clk);
        chk({pd, 2'h0, cmd}, 8'h85);
        i_ce = 0;
        wr(7'h00, 8'h1F);
        chk({pd, 2'h0, cmd}, 8'h85);
        i_ce = 1;
        i_rst_b = 0;
        @(negedge i_clk);
        chk({pd, rpd, ul, ho, so, 3'h0}, 8'h00);
        i_rst_b = 1;
        rd(7'h00, 8'h00);
        rd(7'h01, 8'h00);
        $display("hardware and reset done");
        test_done;
    end
endmodule

// ===== hdl/cbo_command_and_bus_ownership_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// Command and bus ownership control registers
// ****************************************************************
module cbo_command_and_bus_ownership_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input cbo_pkg::cbo_reg_req_t i_req,
    input wire logic i_command_done,
    input wire logic i_wakeup,
    output logic [cbo_pkg::DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_power_down,
    output logic o_radio_power_down,
    output logic [cbo_pkg::CMD_W-1:0] o_command,
    output logic o_ownership_unlock,
    output logic o_host_owns_bus,
    output logic o_secure_module_owns_bus,
    output cbo_pkg::cbo_link_t o_secure_module_link_select
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic sel_cmd;
    wire logic sel_own;
    wire logic wr_cmd;
    wire logic wr_own;
    wire logic rd_any;

    // Register selects; every other address is unmapped
    assign sel_cmd = (i_req.addr == cbo_pkg::OFS_COMMAND_CONTROL);
    assign sel_own = (i_req.addr == cbo_pkg::OFS_HOST_BUS_OWNERSHIP_CONTROL);

    // A write beside a read is taken as the write alone
    assign wr_cmd = i_req.wr & sel_cmd;
    assign wr_own = i_req.wr & sel_own;
    assign rd_any = i_req.rd & ~i_req.wr;

    // ****************************************************************
    // Command control register
    // ****************************************************************
    logic power_down;
    logic radio_power_down;
    logic [cbo_pkg::CMD_W-1:0] command;
    logic next_power_down;
    logic next_radio_power_down;
    logic [cbo_pkg::CMD_W-1:0] next_command;
    wire logic wr_power_down;
    wire logic wr_radio_power_down;
    wire logic [cbo_pkg::CMD_W-1:0] wr_command;

    // Write data split into fields; reserved bit 5 is dropped here
    assign wr_power_down = i_req.wdata[cbo_pkg::CMD_POWER_DOWN_BIT];
    assign wr_radio_power_down = i_req.wdata[cbo_pkg::CMD_RADIO_POWER_DOWN_BIT];
    assign wr_command = i_req.wdata[cbo_pkg::CMD_CODE_MSB:cbo_pkg::CMD_CODE_LSB];

    // Enter power-down
    // Wake-up clears standby, but a write in the same cycle wins
    always_comb begin
        next_power_down = power_down;
        if (i_wakeup) begin
            next_power_down = 1'b0;
        end
        if (wr_cmd) begin
            next_power_down = wr_power_down;
        end
    end

    // Hold command code
    // Completion returns the code to idle unless it is rewritten now
    always_comb begin
        next_command = command;
        if (i_command_done) begin
            next_command = cbo_pkg::CMD_CODE_IDLE;
        end
        if (wr_cmd) begin
            next_command = wr_command;
        end
    end

    // Radio power-down
    // Plain read/write bit, no hardware side effect
    assign next_radio_power_down = wr_cmd ? wr_radio_power_down : radio_power_down;

    // Standby bit, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            power_down <= 1'b0;
        end else if (i_ce) begin
            power_down <= next_power_down;
        end
    end

    // Command code; idle after reset so nothing runs out of reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            command <= cbo_pkg::CMD_CODE_IDLE;
        end else if (i_ce) begin
            command <= next_command;
        end
    end

    // Radio power-down bit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            radio_power_down <= 1'b0;
        end else if (i_ce) begin
            radio_power_down <= next_radio_power_down;
        end
    end

    // ****************************************************************
    // Host bus ownership control register
    // ****************************************************************
    // Unlock, owner grants and link select travel together
    cbo_pkg::cbo_own_t own;
    wire logic own_unlock;
    wire logic own_host;
    wire logic own_secure;
    wire logic [cbo_pkg::LINK_W-1:0] own_link;

    // Every register write counts, so the unlock cannot linger
    cbo_ownership u_ownership (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_any_wr(i_req.wr),
        .i_sel_wr(wr_own),
        .i_wdata(i_req.wdata),
        .o_own(own)
    );

    // Fields of the ownership register for read back and pins
    assign own_unlock = own.unlock;
    assign own_host = own.host;
    assign own_secure = own.secure;
    assign own_link = own.link;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [cbo_pkg::DATA_W-1:0] cmd_image;
    wire logic [cbo_pkg::DATA_W-1:0] own_image;
    wire logic [cbo_pkg::DATA_W-1:0] read_mux;

    // Reserved bits read as zero
    assign cmd_image = {power_down, radio_power_down, 1'b0, command};
    assign own_image = {own_unlock, own_host, own_secure, 1'b0, own_link, 2'h0};
    assign read_mux = sel_cmd ? cmd_image : (sel_own ? own_image : cbo_pkg::READ_ZERO);

    // Read answered one cycle later, valid for exactly one cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= rd_any;
        end
    end

    // Read data held until the next read; unmapped reads give zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= cbo_pkg::READ_ZERO;
        end else if (i_ce && rd_any) begin
            o_rdata <= read_mux;
        end
    end

    // ****************************************************************
    // Registered control outputs
    // ****************************************************************
    // One cycle behind the registers so every output leaves a flop here;
    // a write reaches these pins two edges after it is taken
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_power_down <= 1'b0;
            o_radio_power_down <= 1'b0;
            o_command <= cbo_pkg::CMD_CODE_IDLE;
        end else if (i_ce) begin
            o_power_down <= power_down;
            o_radio_power_down <= radio_power_down;
            o_command <= command;
        end
    end

    // Grants follow the register, which never holds both owners
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ownership_unlock <= 1'b0;
            o_host_owns_bus <= 1'b0;
            o_secure_module_owns_bus <= 1'b0;
        end else if (i_ce) begin
            o_ownership_unlock <= own_unlock;
            o_host_owns_bus <= own_host;
            o_secure_module_owns_bus <= own_secure;
        end
    end

    // Secure module link stays off after reset until software picks one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_secure_module_link_select <= cbo_pkg::CBO_LINK_OFF;
        end else if (i_ce) begin
            o_secure_module_link_select <= cbo_pkg::cbo_link_t'(own_link);
        end
    end

endmodule

// ===== hdl/cbo_ownership.sv
`timescale 1ns/1ps
// ****************************************************************
// Host bus ownership control register
// ****************************************************************
module cbo_ownership (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_any_wr,
    input wire logic i_sel_wr,
    input wire logic [cbo_pkg::DATA_W-1:0] i_wdata,
    output cbo_pkg::cbo_own_t o_own
);

    cbo_pkg::cbo_own_t own;
    cbo_pkg::cbo_own_t next_own;
    wire logic want_host;
    wire logic want_secure;
    wire logic want_both;
    wire logic owner_change_ok;

    // Decode of the requested ownership
    assign want_host = i_wdata[cbo_pkg::HBO_HOST_BIT];
    assign want_secure = i_wdata[cbo_pkg::HBO_SECURE_BIT];
    assign want_both = want_host & want_secure;
    assign owner_change_ok = i_sel_wr & own.unlock & ~want_both;

    // Next state of the ownership register
    always_comb begin
        next_own = own;
        if (i_any_wr) begin
            next_own.unlock = 1'b0;
        end
        // Arming only when not already armed, so an armed write spends it
        if (i_sel_wr && !own.unlock) begin
            next_own.unlock = i_wdata[cbo_pkg::HBO_UNLOCK_BIT];
        end
        if (owner_change_ok) begin
            next_own.host = want_host;
            next_own.secure = want_secure;
        end
        if (i_sel_wr) begin
            next_own.link = i_wdata[cbo_pkg::HBO_LINK_MSB:cbo_pkg::HBO_LINK_LSB];
        end
    end

    // Register, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            own <= '0;
        end else if (i_ce) begin
            own <= next_own;
        end
    end

    assign o_own = own;

endmodule

// ===== hdl/cbo_pkg.sv
// ****************************************************************
// Register map and field layout
// ****************************************************************
package cbo_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CMD_W = 5;
    localparam int LINK_W = 2;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_COMMAND_CONTROL = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_HOST_BUS_OWNERSHIP_CONTROL = 7'h01;

    // Command control fields
    localparam int CMD_POWER_DOWN_BIT = 7;
    localparam int CMD_RADIO_POWER_DOWN_BIT = 6;
    localparam int CMD_CODE_MSB = 4;
    localparam int CMD_CODE_LSB = 0;

    // Host bus ownership control fields
    localparam int HBO_UNLOCK_BIT = 7;
    localparam int HBO_HOST_BIT = 6;
    localparam int HBO_SECURE_BIT = 5;
    localparam int HBO_LINK_MSB = 3;
    localparam int HBO_LINK_LSB = 2;

    // Reset values
    localparam logic [CMD_W-1:0] CMD_CODE_IDLE = 5'h00;
    localparam logic [LINK_W-1:0] LINK_RESET = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // Secure module link selections
    typedef enum logic [LINK_W-1:0] {
        CBO_LINK_OFF = 2'h0,
        CBO_LINK_SPI = 2'h1,
        CBO_LINK_TWO_WIRE_LOW_SPEED = 2'h2,
        CBO_LINK_TWO_WIRE = 2'h3
    } cbo_link_t;

    // Register access request from the host interface logic
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cbo_reg_req_t;

    // Bus ownership state
    typedef struct packed {
        logic unlock;
        logic host;
        logic secure;
        logic [LINK_W-1:0] link;
    } cbo_own_t;

endpackage
